// ### rtl/cib_top.v
// can interrupt identification/acknowledge and bit-timing unit with apb register access
//
// Behaviour
// R1 - identifier shows highest pending, held until cleared
// R2 - status first, then lowest object number
// R3 - object interrupt clears only with its pending
// R4 - status register read clears status interrupt
// R5 - identifier zero means nothing pending
// R6 - irq line while enable set and identifier nonzero
// R7 - status update loads identifier 0x8000
// R8 - writes clear rx/tx success and error code
// R9 - status-change enable gates status interrupts
// R10 - error enable gates error interrupts
// R11 - identifier updates while global enable off
// R12 - readable pending map, one bit per object
// R13 - clear-pending transfer clears bit, identifier advances
// R14 - sync segment is one quantum
// R15 - prescaler 1..64, before-sample segment 1..16, after-sample segment 1..8 quanta
// R16 - quantum equals clock times prescaler
// R17 - segments in one byte, jump/prescaler other
// R18 - timing fields hold value minus one
// R19 - bit lasts before plus after segments plus 3
// R20 - bit timing evaluated once per quantum
// R21 - protocol engine takes bit at sample point
// R22 - zero processing time, phase two minimum
// R23 - resync limited by jump width
// R24 - timing register field order, reset value
// R25 - hard sync on frame start edge
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "cib_defines.vh"
module cib_top (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [11:0]             paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire [`CIB_NUM_OBJ-1:0] obj_irq_set,
    input  wire                    st_update,
    input  wire                    st_err_event,
    input  wire [2:0]              st_err_code,
    input  wire                    st_rx_ok,
    input  wire                    st_tx_ok,
    input  wire                    st_epass,
    input  wire                    st_ewarn,
    input  wire                    st_boff,
    input  wire                    bus_idle,
    input  wire                    tx_bit,
    input  wire                    can_rx,
    output reg                     can_tx,
    output reg                     sample_pulse,
    output reg                     sample_bit,
    output reg                     bit_start,
    output wire                    can_irq
);
    localparam ST_SYNC = 2'b00;
    localparam ST_SEG1 = 2'b01;
    localparam ST_SEG2 = 2'b10;

    reg  [7:0]              control_reg;
    reg  [2:0]              err_code_reg;
    reg                     tx_ok_reg;
    reg                     rx_ok_reg;
    reg                     status_pend_reg;
    reg  [14:0]             bit_timing_reg;
    reg  [`CIB_NUM_OBJ-1:0] object_irq_pending;
    reg                     clr_pend_reg;
    reg                     rx_meta_reg;
    reg                     rx_sync_reg;
    reg                     rx_prev_reg;
    reg  [1:0]              state_reg;
    reg  [4:0]              cnt_reg;
    reg  [4:0]              lim_reg;
    reg                     resync_done_reg;

    wire [15:0]             irq_identifier_reg;
    wire                    tq_tick;
    wire                    wr_en;
    wire                    rd_en;
    wire                    init_mode;
    wire                    global_irq_enable;
    wire                    status_change_irq_enable;
    wire                    error_irq_enable;
    wire                    cfg_change_enable;
    wire [5:0]              quantum_prescaler;
    wire [1:0]              resync_jump_width;
    wire [3:0]              segment_before_sample;
    wire [2:0]              segment_after_sample;
    wire [4:0]              jump_len;
    wire [7:0]              status_reg;
    wire [`CIB_NUM_OBJ-1:0] object_pending_map;
    wire [`CIB_NUM_OBJ-1:0] obj_clr_vec;
    wire                    edge_fall;
    wire                    hard_sync;
    wire                    resync;
    wire                    status_set;
    wire [5:0]              req_obj;
    wire                    req_hit;

    // ---------------- apb slave, zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pslverr = psel && penable
                     && (paddr != `CIB_OFS_CONTROL)
                     && (paddr != `CIB_OFS_STATUS)
                     && (paddr != `CIB_OFS_BIT_TIMING)
                     && (paddr != `CIB_OFS_IRQ_ID)
                     && (paddr != `CIB_OFS_CMD_REQ)
                     && (paddr != `CIB_OFS_CMD_MASK)
                     && (paddr != `CIB_OFS_PEND_MAP);

    assign init_mode                = control_reg[`CIB_CTL_INIT];
    assign global_irq_enable        = control_reg[`CIB_CTL_IRQ_EN];
    assign status_change_irq_enable = control_reg[`CIB_CTL_STS_IRQ_EN];
    assign error_irq_enable         = control_reg[`CIB_CTL_ERR_IRQ_EN];
    assign cfg_change_enable        = control_reg[`CIB_CTL_CCE];

    // minus-one encoded fields, msb to lsb: phase two, before-sample, jump, prescaler
    assign quantum_prescaler     = bit_timing_reg[`CIB_BT_PRESC_MSB:`CIB_BT_PRESC_LSB]; // R17 R24
    assign resync_jump_width     = bit_timing_reg[`CIB_BT_JUMP_MSB:`CIB_BT_JUMP_LSB]; // R17 R24
    assign segment_before_sample = bit_timing_reg[`CIB_BT_BEFORE_MSB:`CIB_BT_BEFORE_LSB]; // R17 R24
    assign segment_after_sample  = bit_timing_reg[`CIB_BT_AFTER_MSB:`CIB_BT_AFTER_LSB]; // R17 R24
    assign jump_len              = {3'b000, resync_jump_width} + 5'h01; // R18

    assign status_reg = {st_boff, st_ewarn, st_epass, rx_ok_reg, tx_ok_reg, err_code_reg};
    assign object_pending_map = object_irq_pending; // R12

    // ---------------- control register
    always @(posedge clk) begin
        if (!rst_n) begin
            control_reg <= `CIB_CTL_RESET;
        end else if (wr_en && paddr == `CIB_OFS_CONTROL) begin
            control_reg <= pwdata[7:0] & 8'h4f;
        end
    end

    // ---------------- bit timing register, writable only in init with config change enabled
    always @(posedge clk) begin
        if (!rst_n) begin
            bit_timing_reg <= `CIB_BT_RESET; // R24
        end else if (wr_en && paddr == `CIB_OFS_BIT_TIMING && init_mode && cfg_change_enable) begin
            bit_timing_reg <= pwdata[14:0]; // R15 R18
        end
    end

    // ---------------- status flags: hardware sets win over software clears
    always @(posedge clk) begin
        if (!rst_n) begin
            err_code_reg <= 3'h0;
            tx_ok_reg    <= 1'b0;
            rx_ok_reg    <= 1'b0;
        end else begin
            if (st_update) begin
                err_code_reg <= st_err_code;
                tx_ok_reg    <= tx_ok_reg | st_tx_ok;
                rx_ok_reg    <= rx_ok_reg | st_rx_ok;
            end else if (wr_en && paddr == `CIB_OFS_STATUS) begin
                // software may only clear these bits, never set them
                err_code_reg <= err_code_reg & pwdata[`CIB_STS_CODE_LSB+2:`CIB_STS_CODE_LSB]; // R8
                tx_ok_reg    <= tx_ok_reg & pwdata[`CIB_STS_TX_OK]; // R8
                rx_ok_reg    <= rx_ok_reg & pwdata[`CIB_STS_RX_OK]; // R8
            end
        end
    end

    // ---------------- status interrupt source
    assign status_set = st_update
                        && (status_change_irq_enable // R9
                            || (st_err_event && error_irq_enable)); // R10

    always @(posedge clk) begin
        if (!rst_n) begin
            status_pend_reg <= 1'b0;
        end else if (status_set) begin
            status_pend_reg <= 1'b1; // R7
        end else if (rd_en && paddr == `CIB_OFS_STATUS) begin
            status_pend_reg <= 1'b0; // R4
        end
    end

    // ---------------- command mask and request: clear-pending transfer
    always @(posedge clk) begin
        if (!rst_n) begin
            clr_pend_reg <= 1'b0;
        end else if (wr_en && paddr == `CIB_OFS_CMD_MASK) begin
            clr_pend_reg <= pwdata[`CIB_MSK_CLR_PEND];
        end
    end

    assign req_obj = pwdata[5:0];
    assign req_hit = wr_en && (paddr == `CIB_OFS_CMD_REQ) && clr_pend_reg
                     && (req_obj != 6'h00) && (req_obj <= 6'd32);

    genvar g;
    generate
        for (g = 0; g < `CIB_NUM_OBJ; g = g + 1) begin : g_obj
            assign obj_clr_vec[g] = req_hit && (req_obj == g + 1); // R13

            always @(posedge clk) begin
                if (!rst_n) begin
                    object_irq_pending[g] <= 1'b0;
                end else if (obj_irq_set[g]) begin
                    object_irq_pending[g] <= 1'b1; // R1
                end else if (obj_clr_vec[g]) begin
                    object_irq_pending[g] <= 1'b0; // R3 R13
                end
            end
        end
    endgenerate

    // identifier follows the pending state regardless of the enable
    cib_irq_prio u_prio (
        .status_pend (status_pend_reg),
        .obj_pend    (object_irq_pending),
        .irq_id      (irq_identifier_reg)
    ); // R1 R11

    assign can_irq = global_irq_enable && (irq_identifier_reg != `CIB_ID_NONE); // R6

    // ---------------- apb read mux
    always @* begin
        prdata = 32'h0000_0000;
        case (paddr)
            `CIB_OFS_CONTROL:    prdata = {24'h000000, control_reg};
            `CIB_OFS_STATUS:     prdata = {24'h000000, status_reg};
            `CIB_OFS_BIT_TIMING: prdata = {17'h00000, bit_timing_reg};
            `CIB_OFS_IRQ_ID:     prdata = {16'h0000, irq_identifier_reg};
            `CIB_OFS_CMD_REQ:    prdata = 32'h0000_0000;
            `CIB_OFS_CMD_MASK:   prdata = {28'h0000000, clr_pend_reg, 3'b000};
            `CIB_OFS_PEND_MAP:   prdata = object_pending_map; // R12
            default:             prdata = 32'h0000_0000;
        endcase
    end

    // ---------------- bus input synchroniser
    always @(posedge clk) begin
        if (!rst_n) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= can_rx;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // ---------------- quantum prescaler, halted in init
    cib_prescaler u_presc (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (!init_mode),
        .div_val (quantum_prescaler),
        .tq_tick (tq_tick)
    ); // R16

    // ---------------- edge detection, sampled once per quantum
    always @(posedge clk) begin
        if (!rst_n) begin
            rx_prev_reg <= 1'b1;
        end else if (tq_tick) begin
            rx_prev_reg <= rx_sync_reg; // R20
        end
    end

    assign edge_fall = tq_tick && rx_prev_reg && !rx_sync_reg;
    assign hard_sync = edge_fall && bus_idle; // R25
    // one resync between sample points, only after a recessive sample, never inside the sync segment
    assign resync    = edge_fall && !bus_idle && !resync_done_reg
                       && sample_bit && (state_reg != ST_SYNC); // R25

    // ---------------- bit time state machine
    always @(posedge clk) begin
        if (!rst_n) begin
            state_reg       <= ST_SYNC;
            cnt_reg         <= 5'h00;
            lim_reg         <= 5'h00;
            resync_done_reg <= 1'b0;
            sample_pulse    <= 1'b0;
            sample_bit      <= 1'b1;
            bit_start       <= 1'b0;
            can_tx          <= 1'b1;
        end else begin
            sample_pulse <= 1'b0;
            bit_start    <= 1'b0;
            if (init_mode) begin
                state_reg       <= ST_SYNC;
                cnt_reg         <= 5'h00;
                resync_done_reg <= 1'b0;
                can_tx          <= 1'b1;
            end else if (hard_sync) begin
                // the edge quantum becomes the sync segment
                state_reg       <= ST_SEG1; // R25 R14
                cnt_reg         <= 5'h00;
                lim_reg         <= {1'b0, segment_before_sample};
                resync_done_reg <= 1'b1;
                bit_start       <= 1'b1;
                can_tx          <= tx_bit;
            end else if (tq_tick) begin // R20
                case (state_reg)
                    ST_SYNC: begin
                        // fixed one-quantum segment
                        state_reg <= ST_SEG1; // R14
                        cnt_reg   <= 5'h00;
                        lim_reg   <= {1'b0, segment_before_sample};
                        bit_start <= 1'b1;
                        can_tx    <= tx_bit;
                    end
                    ST_SEG1: begin
                        if (resync) begin
                            // late edge: lengthen phase one by min(error, jump width)
                            if (cnt_reg + 5'h01 < jump_len) begin
                                lim_reg <= lim_reg + cnt_reg + 5'h01; // R23
                            end else begin
                                lim_reg <= lim_reg + jump_len; // R23
                            end
                            resync_done_reg <= 1'b1;
                            cnt_reg         <= cnt_reg + 5'h01;
                        end else if (cnt_reg >= lim_reg) begin
                            // sample point: engine consumes the bit here
                            sample_bit      <= rx_sync_reg; // R21
                            sample_pulse    <= 1'b1; // R21
                            resync_done_reg <= 1'b0;
                            state_reg       <= ST_SEG2;
                            cnt_reg         <= 5'h00;
                            lim_reg         <= {2'b00, segment_after_sample}; // R19 R22
                        end else begin
                            cnt_reg <= cnt_reg + 5'h01;
                        end
                    end
                    ST_SEG2: begin
                        if (resync && (lim_reg - cnt_reg + 5'h01 <= jump_len)) begin
                            // early edge within reach: it starts the next bit
                            state_reg       <= ST_SEG1; // R23
                            cnt_reg         <= 5'h00;
                            lim_reg         <= {1'b0, segment_before_sample};
                            resync_done_reg <= 1'b1;
                            bit_start       <= 1'b1;
                            can_tx          <= tx_bit;
                        end else if (resync) begin
                            // shorten phase two by the jump width; it keeps at least one quantum, never below processing time
                            lim_reg         <= lim_reg - jump_len; // R23 R22
                            resync_done_reg <= 1'b1;
                            if (cnt_reg + jump_len >= lim_reg) begin
                                state_reg <= ST_SYNC;
                                cnt_reg   <= 5'h00;
                            end else begin
                                cnt_reg <= cnt_reg + 5'h01;
                            end
                        end else if (cnt_reg >= lim_reg) begin
                            state_reg <= ST_SYNC; // R19
                            cnt_reg   <= 5'h00;
                        end else begin
                            cnt_reg <= cnt_reg + 5'h01;
                        end
                    end
                    default: begin
                        state_reg <= ST_SYNC;
                        cnt_reg   <= 5'h00;
                    end
                endcase
            end
        end
    end
endmodule // cib_top

// ### rtl/cib_defines.vh
// register offsets, field positions, reset values and timing figures of the can irq/bit-timing block
`ifndef CIB_DEFINES_VH
`define CIB_DEFINES_VH

`define CIB_OFS_CONTROL     12'h000
`define CIB_OFS_STATUS      12'h004
`define CIB_OFS_BIT_TIMING  12'h00c
`define CIB_OFS_IRQ_ID      12'h010
`define CIB_OFS_CMD_REQ     12'h020
`define CIB_OFS_CMD_MASK    12'h024
`define CIB_OFS_PEND_MAP    12'h140

`define CIB_CTL_INIT        0
`define CIB_CTL_IRQ_EN      1
`define CIB_CTL_STS_IRQ_EN  2
`define CIB_CTL_ERR_IRQ_EN  3
`define CIB_CTL_CCE         6
`define CIB_CTL_RESET       8'h01

`define CIB_STS_CODE_LSB    0
`define CIB_STS_TX_OK       3
`define CIB_STS_RX_OK       4
`define CIB_STS_EPASS       5
`define CIB_STS_EWARN       6
`define CIB_STS_BOFF        7

`define CIB_BT_PRESC_LSB    0
`define CIB_BT_PRESC_MSB    5
`define CIB_BT_JUMP_LSB     6
`define CIB_BT_JUMP_MSB     7
`define CIB_BT_BEFORE_LSB   8
`define CIB_BT_BEFORE_MSB   11
`define CIB_BT_AFTER_LSB    12
`define CIB_BT_AFTER_MSB    14
`define CIB_BT_RESET        15'h2301

`define CIB_MSK_CLR_PEND    3

`define CIB_ID_NONE         16'h0000
`define CIB_ID_STATUS       16'h8000

`define CIB_NUM_OBJ         32
`define CIB_PROC_TIME_TQ    0
`define CIB_PROC_TIME_MAX_TQ 2

`endif

// ### rtl/cib_prescaler.v
// time-quantum prescaler: one-cycle tick every (programmed value + 1) module clocks
`timescale 1ns/1ps
module cib_prescaler (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       run,
    input  wire [5:0] div_val,
    output wire       tq_tick
);
    reg [5:0] cnt_reg;
    reg [5:0] cnt_next;

    // a tick when the count reaches the programmed value: tq = (brp + 1) clocks
    assign tq_tick = run && (cnt_reg >= div_val); // R16

    always @* begin
        cnt_next = cnt_reg + 6'h01;
        if (!run || tq_tick) begin
            cnt_next = 6'h00;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // cib_prescaler

// ### rtl/cib_irq_prio.v
// interrupt identifier encoder: status first, then lowest pending object number
`timescale 1ns/1ps
`include "cib_defines.vh"
module cib_irq_prio (
    input  wire                    status_pend,
    input  wire [`CIB_NUM_OBJ-1:0] obj_pend,
    output reg  [15:0]             irq_id
);
    integer i;

    // scan from the highest object down so the lowest number wins
    always @* begin
        irq_id = `CIB_ID_NONE; // R5
        for (i = `CIB_NUM_OBJ - 1; i >= 0; i = i - 1) begin
            if (obj_pend[i]) begin
                irq_id = i[15:0] + 16'h0001; // R2
            end
        end
        if (status_pend) begin
            irq_id = `CIB_ID_STATUS; // R2 R7
        end
    end
endmodule // cib_irq_prio

// ### tb/cib_top_asserts.sv
// port-level assertions for the can irq/bit-timing block
`timescale 1ns/1ps
module cib_top_asserts (
    input wire        clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        bit_start,
    input wire        sample_pulse,
    input wire        sample_bit,
    input wire        can_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence acc_s;
        psel && penable;
    endsequence
    sequence irq_en_off_s;
        acc_s ##0 (pwrite && paddr == 12'h000 && !pwdata[1]);
    endsequence
    sequence id_zero_s;
        acc_s ##0 (!pwrite && paddr == 12'h010 && prdata == 32'h0);
    endsequence
    apb_ready_a: assert property (acc_s |-> pready) else $error("access without ready");
    err_place_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
    unmapped_a: assert property (acc_s ##0 paddr == 12'h008 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    irq_off_a: assert property (irq_en_off_s |=> !can_irq) else $error("irq line after enable off");
    idle_id_a: assert property (id_zero_s |-> !can_irq) else $error("irq line with zero id");
    start_pulse_a: assert property (bit_start |=> !bit_start) else $error("bit start too long");
    pulses_apart_a: assert property (!(bit_start && sample_pulse)) else $error("sample in sync");
    sample_hold_a: assert property (!$stable(sample_bit) |-> sample_pulse)
        else $error("sampled bit moved off sample point");
endmodule // cib_top_asserts
bind cib_top cib_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_start(bit_start), .sample_pulse(sample_pulse),
    .sample_bit(sample_bit), .can_irq(can_irq));

// ### tb/cib_far_node.sv
// remote bus node: sends one dominant stretch, otherwise recessive
`timescale 1ns/1ps
module cib_far_node (
    input  wire       clk,
    input  wire       go,
    input  wire [7:0] len,
    output reg        rx
);
    reg [7:0] cnt_reg;
    initial begin
        rx = 1'b1;
        cnt_reg = 8'h00;
    end
    // released bus falls back to recessive through the pull-up
    always @(posedge clk) begin
        if (go) begin
            cnt_reg <= len;
            rx <= 1'b0;
        end else if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else begin
            cnt_reg <= 8'h00;
            rx <= 1'b1;
        end
    end
endmodule // cib_far_node

// ### tb/can_irq_and_bit_timing_bench.sv
// self-checking bench for the can irq/bit-timing block
`timescale 1ns/1ps
module can_irq_and_bit_timing_bench;
    reg         clk, rst_n, psel, penable, pwrite, st_update, st_rx_ok, st_tx_ok, bus_idle, go, st_err, tx_b;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, obj_irq_set, r;
    reg  [2:0]  st_err_code;
    reg  [7:0]  len;
    wire [31:0] prdata;
    wire        pready, pslverr, can_tx, sample_pulse, sample_bit, bit_start, can_irq, far_rx;
    wire        can_rx;
    int         errors, total_checks, cyc, seed, t0, t1, b;
    logic [31:0] exp_q[$];
    // wired-and bus between both nodes
    assign can_rx = far_rx & can_tx;
    cib_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .obj_irq_set(obj_irq_set), .st_update(st_update), .st_err_event(st_err), .st_err_code(st_err_code),
        .st_rx_ok(st_rx_ok), .st_tx_ok(st_tx_ok), .st_epass(1'b0), .st_ewarn(1'b0), .st_boff(1'b0),
        .bus_idle(bus_idle), .tx_bit(tx_b), .can_rx(can_rx), .can_tx(can_tx),
        .sample_pulse(sample_pulse), .sample_bit(sample_bit), .bit_start(bit_start), .can_irq(can_irq));
    cib_far_node u_far (.clk(clk), .go(go), .len(len), .rx(far_rx));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task check(input [31:0] seen, input [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // read results are compared by the monitor at the access edge
    always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, exp_q.pop_front());
    task apb(input bit wr, input [11:0] a, input [31:0] d, input [31:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        if (!wr) exp_q.push_back(exp);
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task st_pulse;
        @(posedge clk);
        st_update <= 1'b1;
        @(posedge clk);
        st_update <= 1'b0;
    endtask
    // sel 0 waits for a sample point, 1 for a bit start
    task wait_pulse(input int sel, output int at);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(sel == 0 ? sample_pulse === 1'b1 : bit_start === 1'b1) && n < 300);
        if (n >= 300) errors++;
        at = cyc;
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(50 * 40000);
        errors++;
        end_of_test;
    end
    initial begin
        {rst_n, psel, penable, pwrite, st_update, go, bus_idle, st_err} = 8'h00;
        tx_b = 1'b1;
        {paddr, pwdata, obj_irq_set, len, seed} = 0;
        {st_err_code, st_rx_ok, st_tx_ok} = 5'h17;
        seed = 12;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, 12'h000, 0, 32'h1);
        apb(0, 12'h00c, 0, 32'h2301);
        apb(0, 12'h010, 0, 32'h0);
        apb(0, 12'h008, 0, 32'h0);
        r = $random(seed);
        apb(1, 12'h000, r, 0);
        apb(0, 12'h000, 0, r & 32'h4f);
        apb(1, 12'h000, 32'h3, 0);
        $display("test reset and control done");
        @(posedge clk) obj_irq_set <= 32'h24;
        @(posedge clk) obj_irq_set <= 32'h0;
        apb(0, 12'h140, 0, 32'h24);
        apb(0, 12'h010, 0, 32'h3);
        apb(1, 12'h024, 32'h8, 0);
        apb(1, 12'h020, 32'h3, 0);
        apb(0, 12'h010, 0, 32'h6);
        apb(0, 12'h140, 0, 32'h20);
        $display("test object interrupts done");
        st_pulse;
        apb(0, 12'h010, 0, 32'h6);
        apb(1, 12'h000, 32'h7, 0);
        st_pulse;
        apb(0, 12'h010, 0, 32'h8000);
        check({31'h0, can_irq}, 32'h1);
        apb(1, 12'h004, 32'h8, 0);
        apb(0, 12'h010, 0, 32'h8000);
        apb(0, 12'h004, 0, 32'h8);
        apb(0, 12'h010, 0, 32'h6);
        apb(1, 12'h000, 32'h5, 0);
        apb(0, 12'h010, 0, 32'h6);
        check({31'h0, can_irq}, 32'h0);
        apb(1, 12'h000, 32'hb, 0);
        st_err <= 1'b1;
        st_pulse;
        apb(0, 12'h010, 0, 32'h8000);
        apb(0, 12'h004, 0, 32'h1d);
        apb(1, 12'h000, 32'h3, 0);
        st_pulse;
        apb(0, 12'h010, 0, 32'h6);
        st_err <= 1'b0;
        $display("test status interrupt done");
        for (b = 0; b < 2; b++) begin
            apb(1, 12'h000, 32'h41, 0);
            apb(1, 12'h00c, 32'h1600 | b, 0);
            apb(0, 12'h00c, 0, 32'h1600 | b);
            apb(1, 12'h000, 32'h0, 0);
            @(posedge clk);
            bus_idle <= 1'b1;
            go <= 1'b1;
            len <= 8'(50 * (b + 1));
            @(posedge clk) go <= 1'b0;
            do wait_pulse(0, t0); while (sample_bit !== 1'b0 && cyc < 100000);
            bus_idle <= 1'b0;
            wait_pulse(1, t1);
            check(t1 - t0, 3 * (b + 1));
            wait_pulse(0, t1);
            check(t1 - t0, 10 * (b + 1));
            check({31'h0, sample_bit}, 32'h0);
            tx_b <= 1'b0;
            wait_pulse(1, t1);
            check({31'h0, can_tx}, 32'h0);
            tx_b <= 1'b1;
            wait_pulse(1, t1);
            check({31'h0, can_tx}, 32'h1);
            repeat (60 * (b + 1)) @(posedge clk);
        end
        $display("test bit timing done");
        end_of_test;
    end
endmodule // can_irq_and_bit_timing_bench
